// ==== logic/ppec_host.sv ====
// host controller driving a paged parallel eeprom through its pins
`timescale 1ns/1ps
module ppec_host #(
    parameter int unsigned BLC_CYCLES  = ppec_pkg::BLC_CYC,
    parameter int unsigned WC_CYCLES   = ppec_pkg::WC_CYC,
    parameter int unsigned PON_CYCLES  = ppec_pkg::PON_CYC,
    // arbitrary values, index 0 low
    parameter logic [50:0] ON_ADDR     = {17'h01234, 17'h00abc, 17'h01234},
    parameter logic [23:0] ON_DATA     = {8'h3c, 8'hc3, 8'h5a},
    parameter logic [50:0] OFF_ADDR    = {17'h01234, 17'h00abc, 17'h01234},
    parameter logic [23:0] OFF_DATA    = {8'h69, 8'hc3, 8'h5a}
) (
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_b_in,
    // command port
    input  wire logic                cmd_valid_in,
    input  wire ppec_pkg::ppec_cmd_t cmd_in,
    output logic                     cmd_ready_out,
    // answers
    output logic                     rsp_valid_out,
    output logic [7:0]               rsp_data_out,
    output logic                     done_out,
    output logic                     error_out,
    output logic                     busy_out,
    // memory pins
    output ppec_pkg::ppec_pins_t     pins_out,
    input  wire logic [7:0]          data_in
);

    typedef enum logic [8:0] {
        ST_PWR  = 9'h001,
        ST_IDLE = 9'h002,
        ST_RD   = 9'h004,
        ST_WSET = 9'h008,
        ST_WLOW = 9'h010,
        ST_WREC = 9'h020,
        ST_LOAD = 9'h040,
        ST_POLL = 9'h080,
        ST_PGAP = 9'h100
    } ppec_state_t;

    localparam logic [31:0] RD_LD  = 32'(ppec_pkg::RD_CYC - 1);
    localparam logic [31:0] WP_LD  = 32'(ppec_pkg::WP_CYC - 1);
    localparam logic [31:0] REC_LD = 32'(ppec_pkg::REC_CYC - 1);
    localparam logic [31:0] BLC_LD = 32'(BLC_CYCLES - 1);
    localparam logic [31:0] WC_LD  = 32'(WC_CYCLES - 1);
    localparam logic [31:0] PON_LD = 32'(PON_CYCLES - 1);
    localparam logic [7:0]  PG_MAX = 8'(ppec_pkg::PAGE_BYTES);

    ppec_state_t         state;
    ppec_state_t         next_state;
    ppec_pkg::ppec_cmd_t cur;
    logic [1:0]          idx;
    logic [1:0]          next_idx;
    logic [7:0]          byte_cnt;
    logic                page_open;
    logic                chk7;
    logic                want7;
    logic                have_prev;
    logic                prev_tog;
    logic [16:0]         poll_addr;
    logic [7:0]          data_meta;
    logic [7:0]          data_sync;
    logic                tmr_load;
    logic [31:0]         tmr_val;
    logic                tmr_exp;
    logic                poll_exp;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_meta <= ppec_pkg::DATA_RST;
            data_sync <= ppec_pkg::DATA_RST;
        end else begin
            data_meta <= data_in; // R24
            data_sync <= data_meta;
        end
    end

    // phase timer starts out counting the power-on hold-off
    ppec_timer #(
        .W       (ppec_pkg::TIMER_W),
        .RST_VAL (PON_LD)
    ) u_phase (
        .clock_in    (clock_in),
        .rst_b_in    (rst_b_in),
        .load_in     (tmr_load),
        .value_in    (tmr_val),
        .expired_out (tmr_exp)
    );

    ppec_timer #(
        .W       (ppec_pkg::TIMER_W),
        .RST_VAL ('0)
    ) u_poll (
        .clock_in    (clock_in),
        .rst_b_in    (rst_b_in),
        .load_in     (poll_start),
        .value_in    (WC_LD),
        .expired_out (poll_exp)
    );

    wire        is_lock   = (cur.op == ppec_pkg::OP_LOCK_ON) || (cur.op == ppec_pkg::OP_LOCK_OFF);
    wire [50:0] seq_addr  = (cur.op == ppec_pkg::OP_LOCK_OFF) ? OFF_ADDR : ON_ADDR; // R23
    wire [23:0] seq_data  = (cur.op == ppec_pkg::OP_LOCK_OFF) ? OFF_DATA : ON_DATA;
    wire [16:0] eff_addr  = cur.id_sel ? (ppec_pkg::ID_BASE | {10'h000, cur.addr[6:0]}) : cur.addr; // R22
    wire        pay_byte  = (idx == 2'h3);
    wire [16:0] byte_addr = pay_byte ? eff_addr : seq_addr[idx * 17 +: 17]; // R17 R18
    wire [7:0]  byte_data = pay_byte ? cur.data : seq_data[idx * 8 +: 8];
    wire        seq_end   = pay_byte || ((idx == 2'h2) && is_lock);
    wire        seq_first = (cmd_in.op != ppec_pkg::OP_WRITE) && (cmd_in.op != ppec_pkg::OP_READ);

    wire same_page = (cmd_in.addr[16:7] == cur.addr[16:7]) || cur.id_sel; // R10
    wire cont_ok   = page_open && !tmr_exp && (cmd_in.op == ppec_pkg::OP_WRITE)
                     && (cmd_in.id_sel == cur.id_sel) && same_page; // R8 R11
    wire cont_take = (state == ST_LOAD) && cmd_valid_in && cont_ok;
    wire idle_take = (state == ST_IDLE) && cmd_valid_in;
    wire take      = idle_take || cont_take;
    wire poll_start = (state == ST_LOAD) && tmr_exp && !cont_take;

    wire tog_same = have_prev && (data_sync[ppec_pkg::TOGGLE_BIT] == prev_tog); // R13
    wire top_ok   = !chk7 || (data_sync[ppec_pkg::COMPLETION_BIT] == want7); // R12
    wire poll_ok  = tog_same && top_ok;

    assign cmd_ready_out = (state == ST_IDLE) || ((state == ST_LOAD) && cont_ok);
    assign busy_out      = (state != ST_IDLE);

    always_comb begin
        next_state = state;
        next_idx   = idx;
        tmr_load   = 1'b0;
        tmr_val    = RD_LD;
        unique case (state)
            ST_PWR: begin
                if (tmr_exp) begin // R14
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (idle_take && (cmd_in.op == ppec_pkg::OP_READ)) begin
                    next_state = ST_RD;
                    tmr_load   = 1'b1;
                end else if (idle_take) begin
                    next_state = ST_WSET;
                    next_idx   = seq_first ? 2'h0 : 2'h3; // R18 R21
                end
            end
            ST_RD: begin
                if (tmr_exp) begin // R1
                    next_state = ST_IDLE;
                end
            end
            ST_WSET: begin
                next_state = ST_WLOW;
                tmr_load   = 1'b1;
                tmr_val    = WP_LD; // R16
            end
            ST_WLOW: begin
                if (tmr_exp) begin
                    next_state = ST_WREC;
                    tmr_load   = 1'b1;
                    tmr_val    = REC_LD;
                end
            end
            ST_WREC: begin
                if (tmr_exp && seq_end) begin
                    next_state = ST_LOAD;
                    tmr_load   = 1'b1;
                    tmr_val    = BLC_LD; // R20
                end else if (tmr_exp) begin
                    next_state = ST_WSET;
                    next_idx   = idx + 2'h1;
                end
            end
            ST_LOAD: begin
                if (cont_take) begin // R7
                    next_state = ST_WSET;
                    next_idx   = 2'h3;
                end else if (tmr_exp) begin // R9
                    next_state = ST_POLL;
                    tmr_load   = 1'b1;
                end
            end
            ST_POLL: begin
                if (tmr_exp && (poll_ok || poll_exp)) begin // R6
                    next_state = ST_IDLE;
                end else if (tmr_exp) begin
                    next_state = ST_PGAP;
                    tmr_load   = 1'b1;
                    tmr_val    = REC_LD;
                end
            end
            ST_PGAP: begin
                if (tmr_exp) begin
                    next_state = ST_POLL;
                    tmr_load   = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_PWR;
            idx   <= ppec_pkg::IDX_RST;
        end else begin
            state <= next_state;
            idx   <= next_idx;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cur       <= '0;
            byte_cnt  <= ppec_pkg::CNT_RST;
            page_open <= 1'b0;
        end else if (take) begin
            cur       <= cmd_in;
            byte_cnt  <= idle_take ? ppec_pkg::CNT_RST : byte_cnt;
            page_open <= 1'b0;
        end else if ((state == ST_WREC) && tmr_exp && seq_end) begin
            byte_cnt  <= byte_cnt + {7'h00, pay_byte};
            page_open <= pay_byte && !cur.last && (byte_cnt + 8'h01 < PG_MAX); // R7
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            poll_addr <= ppec_pkg::ADDR_RST;
            chk7      <= 1'b0;
            want7     <= 1'b0;
        end else if ((state == ST_WLOW) && tmr_exp) begin
            poll_addr <= byte_addr;
            chk7      <= pay_byte; // R20
            want7     <= byte_data[ppec_pkg::COMPLETION_BIT];
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            have_prev <= 1'b0;
            prev_tog  <= 1'b0;
        end else if (poll_start) begin
            have_prev <= 1'b0;
        end else if ((state == ST_POLL) && tmr_exp) begin
            have_prev <= 1'b1;
            prev_tog  <= data_sync[ppec_pkg::TOGGLE_BIT]; // R13
        end
    end

    // answers
    wire rd_end   = (state == ST_RD) && tmr_exp;
    wire poll_end = (state == ST_POLL) && tmr_exp && (poll_ok || poll_exp);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= ppec_pkg::DATA_RST;
            done_out      <= 1'b0;
            error_out     <= 1'b0;
        end else begin
            rsp_valid_out <= rd_end;
            rsp_data_out  <= rd_end ? data_sync : rsp_data_out;
            done_out      <= poll_end;
            error_out     <= (poll_end && !poll_ok) || (error_out && !idle_take); // R6
        end
    end

    // pin drive, registered one cycle behind the state
    wire in_rd   = (state == ST_RD) || (state == ST_POLL);
    wire in_wr   = (state == ST_WSET) || (state == ST_WLOW) || (state == ST_WREC);
    wire in_poll = (state == ST_POLL) || (state == ST_PGAP);

    ppec_pkg::ppec_pins_t next_pins;

    always_comb begin
        next_pins                = pins_out;
        next_pins.chip_select_n  = !(in_rd || (state == ST_WSET) || (state == ST_WLOW)); // R3 R4 R5
        next_pins.output_gate_n  = !in_rd; // R2 R15
        next_pins.store_strobe_n = (state != ST_WLOW); // R3
        next_pins.data_oe        = in_wr;
        next_pins.id_select_line = cur.id_sel && (state != ST_IDLE) && (state != ST_PWR); // R22
        if (in_wr) begin
            next_pins.addr = byte_addr;
            next_pins.data = byte_data;
        end else if (in_poll) begin
            next_pins.addr = poll_addr; // R12
        end else if (state == ST_RD) begin
            next_pins.addr = eff_addr;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pins_out <= ppec_pkg::PINS_RST;
        end else begin
            pins_out <= next_pins;
        end
    end

endmodule

// ==== logic/ppec_timer.sv ====
// down counter that flags expiry, loaded per phase
`timescale 1ns/1ps
module ppec_timer #(
    parameter int unsigned W       = 32,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clock_in,
    input  wire logic         rst_b_in,
    // control
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    // status
    output logic              expired_out
);

    logic [W-1:0] count;
    wire          running = (count != '0);

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= RST_VAL;
        end else if (load_in) begin
            count <= value_in;
        end else if (running) begin
            count <= count - W'(1);
        end
    end

    assign expired_out = !running;

endmodule

// ==== shared/ppec_pkg.sv ====
// constants, command and pin types for the paged eeprom host controller
// Overview of operation
// R1 - device drives addressed byte while select and gate low, strobe high
// R2 - device floats data whenever select or gate is high
// R3 - write starts on strobe or select low pulse with gate held high
// R4 - device latches address on the later falling select/strobe edge
// R5 - device latches data on the first rising select/strobe edge
// R6 - program cycle self-timed, at most 10 ms; reads meanwhile only poll
// R7 - one to 128 bytes per programming period
// R8 - host presents each further page byte within 150 us of previous
// R9 - window expiry without new byte ends the load and starts programming
// R10 - host keeps page lines identical for every byte of one load
// R11 - byte lines pick byte, any order, overwrites allowed, only loaded bytes stored
// R12 - polled last byte reads inverted top bit until programming completes
// R13 - toggle bit flips on every read while programming, then stops
// R14 - writes blocked at low supply and about 5 ms after it rises
// R15 - no write starts with gate low, select high or strobe high
// R16 - select/strobe low pulses under about 15 ns are ignored
// R17 - three-byte sequence enables write lock after one program cycle
// R18 - locked device still writes data preceded by the same sequence
// R19 - lock persists across power cycles until disable sequence
// R20 - sequences follow page timing, are not stored, addresses stay writable
// R21 - locked unguarded write starts timers, stores nothing, reads poll
// R22 - 128 id bytes at 1ff80h-1ffffh with id select line elevated
// R23 - sequence addresses and data bytes are design parameters
// R24 - pins sampled on local clock, delays counted in clock cycles
package ppec_pkg;

    localparam int unsigned PAGE_BYTES     = 128;
    localparam int unsigned COMPLETION_BIT = 7;
    localparam int unsigned TOGGLE_BIT     = 6;
    localparam int unsigned TIMER_W        = 32;
    localparam logic [16:0] ID_BASE        = 17'h1ff80;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned CYC_PER_US    = 1000000 / CLK_PERIOD_PS;
    localparam int unsigned CYC_PER_MS    = 1000000000 / CLK_PERIOD_PS;
    localparam int unsigned T_ACC_NS      = 150;
    localparam int unsigned T_WP_NS       = 100;
    localparam int unsigned T_REC_NS      = 50;
    localparam int unsigned T_BLC_US      = 150;
    localparam int unsigned T_WC_MS       = 10;
    localparam int unsigned T_PON_MS      = 5;
    localparam int unsigned SYNC_CYC      = 2;
    localparam int unsigned ACC_CYC       = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WP_CYC        = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned REC_CYC       = (T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // one extra cycle covers the registered pin stage
    localparam int unsigned RD_CYC        = ACC_CYC + SYNC_CYC + 1;
    localparam int unsigned BLC_CYC       = T_BLC_US * CYC_PER_US;
    localparam int unsigned WC_CYC        = T_WC_MS * CYC_PER_MS;
    localparam int unsigned PON_CYC       = T_PON_MS * CYC_PER_MS;

    localparam logic [1:0]  IDX_RST  = 2'h0;
    localparam logic [7:0]  CNT_RST  = 8'h00;
    localparam logic [16:0] ADDR_RST = 17'h00000;
    localparam logic [7:0]  DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        OP_READ          = 3'h0,
        OP_WRITE         = 3'h1,
        OP_GUARDED_WRITE = 3'h2,
        OP_LOCK_ON       = 3'h3,
        OP_LOCK_OFF      = 3'h4
    } ppec_op_t;

    typedef struct packed {
        ppec_op_t    op;
        logic        id_sel;
        logic        last;
        logic [16:0] addr;
        logic [7:0]  data;
    } ppec_cmd_t;

    typedef struct packed {
        logic        chip_select_n;
        logic        output_gate_n;
        logic        store_strobe_n;
        logic        id_select_line;
        logic [16:0] addr;
        logic [7:0]  data;
        logic        data_oe;
    } ppec_pins_t;

    localparam ppec_pins_t PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b0, 17'h00000, 8'h00, 1'b0};

endpackage

// ==== tb/ppec_eeprom_model.sv ====
// behavioural paged eeprom answering the host pins
`timescale 1ns/1ps
module ppec_eeprom_model #(
    parameter realtime     BLC_NS   = 200.0,
    parameter realtime     PON_NS   = 100.0,
    // arbitrary values, index 0 low
    parameter logic [50:0] ON_ADDR  = {17'h01234, 17'h00abc, 17'h01234},
    parameter logic [23:0] ON_DATA  = {8'h3c, 8'hc3, 8'h5a},
    parameter logic [50:0] OFF_ADDR = {17'h01234, 17'h00abc, 17'h01234},
    parameter logic [23:0] OFF_DATA = {8'h69, 8'hc3, 8'h5a}
) (
    // pins from host
    input  wire ppec_pkg::ppec_pins_t pins_in,
    // data to host
    output wire logic [7:0]           data_out
);
    realtime     prog_ns = 1000.0;
    realtime     t_fall;
    realtime     t_last;
    realtime     t0;
    logic [7:0]  mem [0:131071];
    logic [7:0]  idm [0:127];
    logic [16:0] pa [$];
    logic [7:0]  pd [$];
    logic [16:0] a_lat;
    logic [7:0]  last_d = 8'h00;
    logic [7:0]  drv;
    logic        page_id = 1'b0;
    logic        busy = 1'b0;
    logic        locked = 1'b0;
    logic        tog = 1'b0;
    event        kick;
    wire         wr_n  = pins_in.chip_select_n | pins_in.store_strobe_n;
    wire         rd_en = !pins_in.chip_select_n && !pins_in.output_gate_n && pins_in.store_strobe_n;

    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (idm[i]) idm[i] = 8'hff;
    end
    assign drv = busy ? {~last_d[7], tog, last_d[5:0]} :
                 pins_in.id_select_line ? idm[pins_in.addr[6:0]] : mem[pins_in.addr];
    assign data_out = rd_en ? drv : ~drv;

    always @(posedge rd_en) if (busy) tog = ~tog;

    always @(negedge wr_n) begin
        t_fall = $realtime;
        a_lat  = pins_in.addr;
    end

    always @(posedge wr_n) begin
        if (pins_in.output_gate_n && !busy && $realtime >= PON_NS && $realtime - t_fall >= 15.0 && pa.size() < 128) begin
            pa.push_back(a_lat);
            pd.push_back(pins_in.data);
            page_id = pins_in.id_select_line;
            t_last  = $realtime;
            ->kick;
        end
    end

    function automatic bit seq_at(input logic [50:0] a, input logic [23:0] d);
        seq_at = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (pa[i] !== a[17*i +: 17] || pd[i] !== d[8*i +: 8]) seq_at = 1'b0;
        end
    endfunction

    task automatic program_page();
        int n;
        bit on_seq, off_seq;
        n       = pd.size();
        on_seq  = n >= 3 && seq_at(ON_ADDR, ON_DATA);
        off_seq = n == 3 && seq_at(OFF_ADDR, OFF_DATA);
        busy    = 1'b1;
        last_d  = pd[n-1];
        #(prog_ns);
        if (!off_seq && (!locked || on_seq)) begin
            for (int i = on_seq ? 3 : 0; i < n; i++) begin
                if (page_id) begin
                    idm[pa[i][6:0]] = pd[i];
                end else begin
                    mem[pa[i]] = pd[i];
                end
            end
        end
        if (on_seq) locked = 1'b1;
        if (off_seq) locked = 1'b0;
        pa.delete();
        pd.delete();
        busy = 1'b0;
    endtask

    always begin
        @(kick);
        do begin
            t0 = t_last;
            #(BLC_NS);
        end while (t_last != t0);
        program_page();
    end
endmodule

// ==== tb/ppec_host_sva.sv ====
// assertions on the eeprom host pins and answers
`timescale 1ns/1ps
module ppec_host_sva #(
    parameter int unsigned BLC_CYCLES = 40,
    parameter int unsigned PON_CYCLES = 20
) (
    // clock and reset
    input wire logic                 clock_in,
    input wire logic                 rst_b_in,
    // answers and pins
    input wire logic                 rsp_valid_out,
    input wire logic                 done_out,
    input wire logic                 error_out,
    input wire logic                 busy_out,
    input wire ppec_pkg::ppec_pins_t pins_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    logic        strobe_q;
    logic [31:0] gap_cnt;
    logic [31:0] pon_cnt;
    logic        read_seen;
    wire         strobe_n = pins_out.store_strobe_n;
    wire         fell_w   = strobe_q && !strobe_n;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strobe_q  <= 1'b1;
            gap_cnt   <= '0;
            pon_cnt   <= '0;
            read_seen <= 1'b1;
        end else begin
            strobe_q  <= strobe_n;
            gap_cnt   <= (!strobe_q && strobe_n) ? 32'h0 : gap_cnt + 32'h1;
            pon_cnt   <= (pon_cnt < PON_CYCLES) ? pon_cnt + 32'h1 : pon_cnt;
            read_seen <= fell_w ? 1'b0 : (read_seen || !pins_out.output_gate_n);
        end
    end

    property p_write_gate;
        !strobe_n |-> pins_out.output_gate_n && !pins_out.chip_select_n;
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("strobe low without select or with gate low");
    property p_read_gate;
        !pins_out.output_gate_n |-> !pins_out.chip_select_n && strobe_n && !pins_out.data_oe;
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("read cycle with bad select or driven bus");
    property p_pulse_width;
        $fell(strobe_n) |-> (!strobe_n)[*4];
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("strobe pulse too short");
    property p_data_hold;
        $rose(strobe_n) |-> $stable(pins_out.data) && pins_out.data_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");
    property p_addr_hold;
        !strobe_n |=> strobe_n || $stable(pins_out.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved under strobe");
    property p_load_gap;
        fell_w && !read_seen |-> gap_cnt <= BLC_CYCLES;
    endproperty
    a_load_gap: assert property (p_load_gap) else $error("page byte after load window");
    property p_power_wait;
        !strobe_n |-> pon_cnt >= PON_CYCLES && busy_out;
    endproperty
    a_power_wait: assert property (p_power_wait) else $error("strobe during power-on wait");
    property p_id_window;
        pins_out.id_select_line && !pins_out.chip_select_n |-> pins_out.addr[16:7] == 10'h3ff;
    endproperty
    a_id_window: assert property (p_id_window) else $error("id access outside id window");
    property p_rsp_pulse;
        rsp_valid_out |=> !rsp_valid_out;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("read answer longer than one cycle");

    c_read: cover property (rsp_valid_out);
    c_done: cover property (done_out);
    c_error: cover property ($rose(error_out));
    c_id_write: cover property (pins_out.id_select_line && !strobe_n);
endmodule

bind ppec_host ppec_host_sva #(.BLC_CYCLES(BLC_CYCLES), .PON_CYCLES(PON_CYCLES)) u_ppec_host_sva (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .rsp_valid_out(rsp_valid_out), .done_out(done_out),
    .error_out(error_out), .busy_out(busy_out), .pins_out(pins_out));

// ==== tb/ppec_host_tb_top.sv ====
// self-checking bench for the paged eeprom host controller
`timescale 1ns/1ps
module ppec_host_tb_top;
    logic                 clock_in = 1'b0;
    logic                 rst_b_in = 1'b0;
    logic                 cmd_valid_in = 1'b0;
    ppec_pkg::ppec_cmd_t  cmd_in = '0;
    logic                 cmd_ready_out;
    logic                 rsp_valid_out;
    logic [7:0]           rsp_data_out;
    logic                 done_out;
    logic                 error_out;
    logic                 busy_out;
    ppec_pkg::ppec_pins_t pins_out;
    logic [7:0]           data_in;
    int                   err_total = 0;
    int                   n_compared = 0;

    always #2.5 clock_in = ~clock_in;

    ppec_host #(.BLC_CYCLES(40), .WC_CYCLES(2000), .PON_CYCLES(20)) u_ppec_host (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
        .done_out(done_out), .error_out(error_out), .busy_out(busy_out), .pins_out(pins_out), .data_in(data_in));
    ppec_eeprom_model u_ppec_eeprom_model (.pins_in(pins_out), .data_out(data_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reset_host();
        @(posedge clock_in);
        rst_b_in <= 1'b0;
        repeat (12) @(posedge clock_in);
        rst_b_in <= 1'b1;
    endtask

    task automatic send(input ppec_pkg::ppec_op_t op, input logic id, input logic last,
                        input logic [16:0] addr, input logic [7:0] data);
        int n = 0;
        @(posedge clock_in);
        cmd_valid_in <= 1'b1;
        cmd_in       <= '{op, id, last, addr, data};
        do @(negedge clock_in); while (cmd_ready_out !== 1'b1 && ++n < 20000);
        @(posedge clock_in);
        cmd_valid_in <= 1'b0;
    endtask

    task automatic finish_op(input logic exp_err);
        int n = 0;
        do @(negedge clock_in); while (done_out !== 1'b1 && ++n < 20000);
        @(negedge clock_in);
        chk({7'h00, done_out === 1'b0 && n < 20000}, 8'h01, "done pulse");
        chk({7'h00, error_out}, {7'h00, exp_err}, "error flag");
        chk({6'h00, busy_out, cmd_ready_out}, 8'h01, "idle after done");
    endtask

    task automatic write(input logic [16:0] addr, input logic [7:0] data, input logic exp_err);
        send(ppec_pkg::OP_WRITE, 1'b0, 1'b1, addr, data);
        finish_op(exp_err);
    endtask

    task automatic read_chk(input logic id, input logic [16:0] addr, input logic [7:0] exp);
        int n = 0;
        send(ppec_pkg::OP_READ, id, 1'b1, addr, 8'h00);
        do @(negedge clock_in); while (rsp_valid_out !== 1'b1 && ++n < 100);
        chk(rsp_valid_out === 1'b1 ? rsp_data_out : ~exp, exp, "read data");
    endtask

    task automatic t_byte();
        write(17'h00123, 8'h5a, 1'b0);
        read_chk(1'b0, 17'h00123, 8'h5a);
        send(ppec_pkg::OP_WRITE, 1'b1, 1'b1, 17'h00005, 8'h4e);
        finish_op(1'b0);
        read_chk(1'b1, 17'h00005, 8'h4e);
        read_chk(1'b0, 17'h1ff85, 8'hff);
    endtask

    task automatic t_page();
        send(ppec_pkg::OP_WRITE, 1'b0, 1'b0, 17'h00205, 8'h11);
        send(ppec_pkg::OP_WRITE, 1'b0, 1'b0, 17'h00201, 8'h22);
        send(ppec_pkg::OP_WRITE, 1'b0, 1'b1, 17'h00205, 8'h33);
        finish_op(1'b0);
        read_chk(1'b0, 17'h00205, 8'h33);
        read_chk(1'b0, 17'h00201, 8'h22);
        read_chk(1'b0, 17'h00202, 8'hff);
    endtask

    task automatic t_full();
        for (int i = 0; i < 128; i++) begin
            send(ppec_pkg::OP_WRITE, 1'b0, 1'b0, {10'h010, i[6:0]}, i[7:0] ^ 8'ha5);
        end
        finish_op(1'b0);
        read_chk(1'b0, 17'h00800, 8'ha5);
        read_chk(1'b0, 17'h0087f, 8'hda);
    endtask

    task automatic t_slow();
        u_ppec_eeprom_model.prog_ns = 12000.0;
        write(17'h00400, 8'h81, 1'b1);
        #4000;
        u_ppec_eeprom_model.prog_ns = 1000.0;
        read_chk(1'b0, 17'h00400, 8'h81);
        chk({7'h00, error_out}, 8'h00, "error cleared");
    endtask

    task automatic t_lock();
        send(ppec_pkg::OP_LOCK_ON, 1'b0, 1'b1, 17'h00000, 8'h00);
        finish_op(1'b0);
        reset_host();
        write(17'h00300, 8'h9a, 1'b0);
        read_chk(1'b0, 17'h00300, 8'hff);
        send(ppec_pkg::OP_GUARDED_WRITE, 1'b0, 1'b1, 17'h00301, 8'hb4);
        finish_op(1'b0);
        read_chk(1'b0, 17'h00301, 8'hb4);
        read_chk(1'b0, 17'h01234, 8'hff);
        send(ppec_pkg::OP_LOCK_OFF, 1'b0, 1'b1, 17'h00000, 8'h00);
        finish_op(1'b0);
        write(17'h01234, 8'h77, 1'b0);
        read_chk(1'b0, 17'h01234, 8'h77);
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        reset_host();
        t_byte();
        t_page();
        t_full();
        t_slow();
        t_lock();
        give_verdict();
    end
endmodule
